//--- common/asu_pkg.sv
// Shared constants, register map and helpers for the async serial unit.
package asu_pkg;
  // ---------------------------------------------------------------
  // Register byte offsets on the Wishbone slave
  // ---------------------------------------------------------------
  localparam logic [7:0] ASU_OFS_STATUS = 8'h00;
  localparam logic [7:0] ASU_OFS_DATA = 8'h04;
  localparam logic [7:0] ASU_OFS_CTRL1 = 8'h08;
  localparam logic [7:0] ASU_OFS_CTRL2 = 8'h0c;
  localparam logic [7:0] ASU_OFS_BAUD = 8'h10;
  localparam logic [7:0] ASU_OFS_RXFINE = 8'h14;
  localparam logic [7:0] ASU_OFS_TXFINE = 8'h18;
  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int ASU_B_TIE = 7;
  localparam int ASU_B_TX_DONE_IRQ_ENABLE = 6;
  localparam int ASU_B_RIE = 5;
  localparam int ASU_B_IDLE_IRQ_ENABLE = 4;
  localparam int ASU_B_TE = 3;
  localparam int ASU_B_RE = 2;
  localparam int ASU_B_SBK = 0;
  localparam int ASU_B_R8 = 7;
  localparam int ASU_B_T8 = 6;
  localparam int ASU_B_M = 4;
  localparam int ASU_B_WAKE = 3;
  // ---------------------------------------------------------------
  // Reset values and timing counts
  // ---------------------------------------------------------------
  localparam logic [7:0] ASU_RST_CTRL = 8'h00;
  localparam logic [7:0] ASU_RST_BAUD = 8'h00;
  localparam logic [7:0] ASU_RST_FINE = 8'h00;
  localparam logic ASU_RST_TC = 1'b1;
  localparam logic [3:0] ASU_OVS_LAST = 4'hf;
  localparam logic [3:0] ASU_SMP_FIRST = 4'h7;
  localparam logic [3:0] ASU_SMP_LAST = 4'h9;
  localparam logic [3:0] ASU_FRAME_BITS = 4'ha;
  localparam logic [3:0] ASU_CONV_SHIFT = 4'h1;

  // Coarse prescale code to division factor.
  function automatic logic [3:0] asu_pr_factor(input logic [1:0] code);
    case (code)
      2'b00: asu_pr_factor = 4'h1;
      2'b01: asu_pr_factor = 4'h3;
      2'b10: asu_pr_factor = 4'h4;
      default: asu_pr_factor = 4'hd;
    endcase
  endfunction : asu_pr_factor
endpackage : asu_pkg

//--- common/asu_rx_if.sv
// Received-frame events passed from the receive core to the top.
`timescale 1ns/1ps
`default_nettype none
interface asu_rx_if;
  logic done;
  logic idle;
  logic [8:0] data;
  logic noise;
  logic ferr;
  modport core (output done, output idle, output data, output noise, output ferr);
  modport user (input done, input idle, input data, input noise, input ferr);
endinterface : asu_rx_if
`default_nettype wire

//--- logic/asu_baud.sv
// Oversampling tick generator for one direction, conventional or fine path.
`timescale 1ns/1ps
`default_nettype none
module asu_baud
  import asu_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Rate selection
  input wire logic run,
  input wire logic [1:0] prescale,
  input wire logic [2:0] exponent,
  input wire logic [7:0] fine,
  // Sixteen ticks per bit
  output logic tick
);
  logic [11:0] per;
  logic [11:0] cnt_r, cnt_nxt;
  logic tick_nxt;

  // Tick period in clocks: 2*PR*2^n conventional, or the fine value.
  always_comb begin
    if (fine != 8'h00) begin
      per = {4'h0, fine};
    end else begin
      per = {8'h00, asu_pr_factor(prescale)} << ({1'b0, exponent} + ASU_CONV_SHIFT);
    end
    cnt_nxt = 12'h000;
    tick_nxt = 1'b0;
    if (run) begin
      if (cnt_r == per - 12'h001) begin
        tick_nxt = 1'b1;
      end else begin
        cnt_nxt = cnt_r + 12'h001;
      end
    end
  end

  // Registers only.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cnt_r <= 12'h000;
      tick <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      tick <= tick_nxt;
    end
  end
endmodule : asu_baud
`default_nettype wire

//--- logic/asu_rx_core.sv
// Receive deserialiser with three-sample voting, framing and idle-line detection.
`timescale 1ns/1ps
`default_nettype none
module asu_rx_core
  import asu_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Control
  input wire logic enable,
  input wire logic tick,
  input wire logic rxd,
  input wire logic nine_bit,
  // Frame events
  asu_rx_if.core ev
);
  typedef enum logic [1:0] {RC_IDLE, RC_START, RC_DATA, RC_STOP} asu_rc_e;
  asu_rc_e st_r, st_nxt;
  logic [3:0] sub_r, sub_nxt, bit_r, bit_nxt;
  logic [8:0] sh_r, sh_nxt, data_r, data_nxt;
  logic [1:0] ones_r, ones_nxt;
  logic [7:0] icnt_r, icnt_nxt;
  logic noisy_r, noisy_nxt, iarm_r, iarm_nxt;
  logic done_r, done_nxt, idle_r, idle_nxt, nz_r, nz_nxt, fe_r, fe_nxt;
  logic bitv;

  assign ev.done = done_r;
  assign ev.idle = idle_r;
  assign ev.data = data_r;
  assign ev.noise = nz_r;
  assign ev.ferr = fe_r;

  // Each bit is judged at its last tick from the votes at ticks 7 to 9.
  always_comb begin
    {st_nxt, sub_nxt, bit_nxt, sh_nxt, data_nxt} = {st_r, sub_r, bit_r, sh_r, data_r};
    {ones_nxt, icnt_nxt, noisy_nxt, iarm_nxt} = {ones_r, icnt_r, noisy_r, iarm_r};
    {done_nxt, idle_nxt, nz_nxt, fe_nxt} = {1'b0, 1'b0, nz_r, fe_r};
    bitv = ones_r[1];
    if (!enable) begin
      {st_nxt, icnt_nxt, iarm_nxt} = {RC_IDLE, 8'h00, 1'b1};
    end else if (tick) begin
      if (st_r == RC_IDLE) begin
        icnt_nxt = 8'h00;
        if (!rxd) begin
          {st_nxt, sub_nxt, ones_nxt, noisy_nxt, iarm_nxt} = {RC_START, 4'h1, 2'b00, 1'b0, 1'b1};
        end else if (iarm_r) begin
          // A whole frame of ones is an idle frame, reported once.
          icnt_nxt = icnt_r + 8'h01;
          if (icnt_r == {ASU_FRAME_BITS + {3'b000, nine_bit}, 4'h0} - 8'h01) begin
            {idle_nxt, iarm_nxt} = {1'b1, 1'b0};
          end
        end
      end else begin
        sub_nxt = sub_r + 4'h1;
        if (sub_r >= ASU_SMP_FIRST && sub_r <= ASU_SMP_LAST && rxd) begin
          ones_nxt = ones_r + 2'b01;
        end
        if (sub_r == ASU_OVS_LAST) begin
          ones_nxt = 2'b00;
          noisy_nxt = noisy_r | (ones_r[1] ^ ones_r[0]);
          case (st_r)
            RC_START: begin
              {st_nxt, bit_nxt} = bitv ? {RC_IDLE, 4'h0} : {RC_DATA, 4'h0};
            end
            RC_DATA: begin
              sh_nxt = {bitv, sh_r[8:1]};
              bit_nxt = bit_r + 4'h1;
              if (bit_r == (nine_bit ? 4'h8 : 4'h7)) begin
                st_nxt = RC_STOP;
              end
            end
            default: begin
              // A low stop bit covers both lost sync and a break.
              st_nxt = RC_IDLE;
              data_nxt = nine_bit ? sh_r : {1'b0, sh_r[8:1]};
              {done_nxt, fe_nxt} = {1'b1, ~bitv};
              nz_nxt = noisy_r | (ones_r[1] ^ ones_r[0]);
            end
          endcase
        end
      end
    end
  end

  // Registers only.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      {st_r, sub_r, bit_r, sh_r, data_r} <= {RC_IDLE, 4'h0, 4'h0, 9'h000, 9'h000};
      {ones_r, icnt_r, noisy_r, iarm_r} <= {2'b00, 8'h00, 1'b0, 1'b1};
      {done_r, idle_r, nz_r, fe_r} <= 4'h0;
    end else begin
      {st_r, sub_r, bit_r, sh_r, data_r} <= {st_nxt, sub_nxt, bit_nxt, sh_nxt, data_nxt};
      {ones_r, icnt_r, noisy_r, iarm_r} <= {ones_nxt, icnt_nxt, noisy_nxt, iarm_nxt};
      {done_r, idle_r, nz_r, fe_r} <= {done_nxt, idle_nxt, nz_nxt, fe_nxt};
    end
  end
endmodule : asu_rx_core
`default_nettype wire

//--- logic/asu_top.sv
// Async serial unit: Wishbone registers, transmitter, receive flags, interrupt.
//
// Function
// - idle frame flagged, interrupts if enabled and unmasked
// - full holding register: overrun set, data kept
// - overrun interrupts only with rx enable, unmasked
// - status read then data read clears overrun
// - noise flag rises with full flag, no interrupt
// - status then data read clears noise, framing
// - missing stop bit or break sets framing flag
// - conventional rate is clock/(32*PR*2^n) per direction
// - coarse prescale is one of 1,3,4,13
// - prescale codes 00,01,10,11 give 1,3,4,13
// - nonzero fine divider selects fine path
// - fine rate is clock/16 divided by 1..255
// - mute blocks receive flags and receive interrupts
// - idle wake-up clears mute, no idle flag
// - address wake-up on set MSB, word received
// - wait mode runs on; interrupts request wake-up
// - halt freezes unit; interrupts do not end halt
// - tx empty, tx done, idle have own enables; rx full and overrun share one
// - all events share one masked interrupt line
// - receiver disable clears all receive flags
// - framing plus overrun sets only overrun
// - idle flag rearmed only by new character
//
// The address map and the Wishbone interface to the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
module asu_top
  import asu_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Serial line
  input wire logic rxd_i,
  output logic txd_o,
  output logic txd_oe_o,
  // CPU side
  input wire logic global_irq_mask,
  input wire logic wait_mode_i,
  input wire logic halt_i,
  output logic irq_o,
  output logic wake_req_o
);
  // ---------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------
  logic req, wr, rd, rd_status, rd_data, wr_data, acc_data;
  assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr = req & wb_we_i & wb_sel_i[0];
  assign rd = req & ~wb_we_i;
  assign rd_status = rd & (wb_adr_i == ASU_OFS_STATUS);
  assign acc_data = req & (wb_adr_i == ASU_OFS_DATA);
  assign rd_data = acc_data & ~wb_we_i;
  assign wr_data = wr & (wb_adr_i == ASU_OFS_DATA);

  logic [7:0] ctrl1_r, ctrl1_nxt, ctrl2_r, ctrl2_nxt, baud_r, baud_nxt;
  logic [7:0] rxfine_r, rxfine_nxt, txfine_r, txfine_nxt;
  logic [31:0] dat_nxt;
  logic seen_r, seen_nxt, ack_nxt;
  logic tx_tick, rx_tick, te, re, m;
  logic mute_r, mute_nxt;
  logic rx_full_flag_r, rx_full_flag_nxt, idle_r, idle_nxt, ovr_r, ovr_nxt;
  logic nf_r, nf_nxt, fe_r, fe_nxt, idle_ok_r, idle_ok_nxt, r8_r, r8_nxt;
  logic [7:0] rdr_r, rdr_nxt;
  logic tdr_full_r, tdr_full_nxt, tc_r, tc_nxt;
  logic [7:0] status;
  assign te = ctrl2_r[ASU_B_TE];
  assign re = ctrl2_r[ASU_B_RE];
  assign m = ctrl1_r[ASU_B_M];
  assign status = {~tdr_full_r, tc_r, rx_full_flag_r, idle_r, ovr_r, nf_r, fe_r, 1'b0};

  // ---------------------------------------------------------------
  // Register file and bus answer
  // ---------------------------------------------------------------
  // Every access is acknowledged one cycle after it is seen; unmapped
  // offsets read zero and ignore writes.
  always_comb begin
    {ctrl1_nxt, ctrl2_nxt, baud_nxt} = {ctrl1_r, ctrl2_r, baud_r};
    {rxfine_nxt, txfine_nxt} = {rxfine_r, txfine_r};
    dat_nxt = wb_dat_o;
    seen_nxt = seen_r;
    ack_nxt = req;
    if (req) begin
      if (wb_adr_i == ASU_OFS_STATUS) begin
        dat_nxt = {24'h000000, status};
        seen_nxt = ~wb_we_i;
      end else if (wb_adr_i == ASU_OFS_DATA) begin
        dat_nxt = {24'h000000, rdr_r};
        seen_nxt = 1'b0;
      end else if (wb_adr_i == ASU_OFS_CTRL1) begin
        dat_nxt = {24'h000000, r8_r, ctrl1_r[6:0]};
        if (wr) ctrl1_nxt = wb_dat_i[7:0];
      end else if (wb_adr_i == ASU_OFS_CTRL2) begin
        dat_nxt = {24'h000000, ctrl2_r[7:2], mute_r, ctrl2_r[0]};
        if (wr) ctrl2_nxt = wb_dat_i[7:0];
      end else if (wb_adr_i == ASU_OFS_BAUD) begin
        dat_nxt = {24'h000000, baud_r};
        if (wr) baud_nxt = wb_dat_i[7:0];
      end else if (wb_adr_i == ASU_OFS_RXFINE) begin
        dat_nxt = {24'h000000, rxfine_r};
        if (wr) rxfine_nxt = wb_dat_i[7:0];
      end else if (wb_adr_i == ASU_OFS_TXFINE) begin
        dat_nxt = {24'h000000, txfine_r};
        if (wr) txfine_nxt = wb_dat_i[7:0];
      end else begin
        dat_nxt = 32'h00000000;
      end
    end
  end

  // Registers only.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      {ctrl1_r, ctrl2_r, baud_r} <= {ASU_RST_CTRL, ASU_RST_CTRL, ASU_RST_BAUD};
      {rxfine_r, txfine_r} <= {ASU_RST_FINE, ASU_RST_FINE};
      wb_dat_o <= 32'h00000000;
      {seen_r, wb_ack_o} <= 2'b00;
    end else begin
      {ctrl1_r, ctrl2_r, baud_r} <= {ctrl1_nxt, ctrl2_nxt, baud_nxt};
      {rxfine_r, txfine_r} <= {rxfine_nxt, txfine_nxt};
      wb_dat_o <= dat_nxt;
      {seen_r, wb_ack_o} <= {seen_nxt, ack_nxt};
    end
  end

  // ---------------------------------------------------------------
  // Rate generators
  // ---------------------------------------------------------------
  // Halt stops both generators, so no frame advances and every flag holds.
  asu_baud u_tx_baud (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .run(te & ~halt_i),
    .prescale(baud_r[7:6]),
    .exponent(baud_r[5:3]),
    .fine(txfine_r),
    .tick(tx_tick)
  );

  asu_baud u_rx_baud (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .run(re & ~halt_i),
    .prescale(baud_r[7:6]),
    .exponent(baud_r[2:0]),
    .fine(rxfine_r),
    .tick(rx_tick)
  );

  // ---------------------------------------------------------------
  // Transmitter
  // ---------------------------------------------------------------
  typedef enum logic {TX_IDLE, TX_SEND} asu_tx_e;
  asu_tx_e tst_r, tst_nxt;
  logic [10:0] tsh_r, tsh_nxt;
  logic [3:0] tbits_r, tbits_nxt, tsub_r, tsub_nxt, flen;
  logic [8:0] tdr_r, tdr_nxt;
  logic te_d_r, pre_r, pre_nxt, brk_r, brk_nxt, txd_nxt;
  assign flen = ASU_FRAME_BITS + {3'b000, m};

  // A rising enable queues one idle frame; break frames repeat while
  // requested and are closed by a single high bit.
  always_comb begin
    {tst_nxt, tsh_nxt, tbits_nxt, tsub_nxt} = {tst_r, tsh_r, tbits_r, tsub_r};
    {tdr_nxt, tdr_full_nxt, tc_nxt} = {tdr_r, tdr_full_r, tc_r};
    {pre_nxt, brk_nxt} = {pre_r | (te & ~te_d_r), brk_r};
    if (wr_data) begin
      {tdr_nxt, tdr_full_nxt} = {ctrl1_r[ASU_B_T8], wb_dat_i[7:0], 1'b1};
      if (seen_r) tc_nxt = 1'b0;
    end
    if (!te) begin
      {tst_nxt, tsub_nxt} = {TX_IDLE, 4'h0};
    end else if (tst_r == TX_IDLE && tx_tick) begin
      tsub_nxt = 4'h0;
      if (pre_r) begin
        {tst_nxt, tsh_nxt, tbits_nxt, pre_nxt} = {TX_SEND, 11'h7ff, flen, 1'b0};
      end else if (ctrl2_r[ASU_B_SBK]) begin
        {tst_nxt, tsh_nxt, tbits_nxt, brk_nxt} = {TX_SEND, 11'h000, flen, 1'b1};
      end else if (brk_r) begin
        {tst_nxt, tsh_nxt, tbits_nxt, brk_nxt} = {TX_SEND, 11'h7ff, 4'h1, 1'b0};
      end else if (tdr_full_r) begin
        tst_nxt = TX_SEND;
        tsh_nxt = m ? {1'b1, tdr_r, 1'b0} : {2'b11, tdr_r[7:0], 1'b0};
        {tbits_nxt, tdr_full_nxt} = {flen, wr_data};
      end
    end else if (tx_tick) begin
      tsub_nxt = tsub_r + 4'h1;
      if (tsub_r == ASU_OVS_LAST) begin
        {tsh_nxt, tbits_nxt} = {{1'b1, tsh_r[10:1]}, tbits_r - 4'h1};
        if (tbits_r == 4'h1) begin
          {tst_nxt, tc_nxt} = {TX_IDLE, 1'b1};
        end
      end
    end
    txd_nxt = (te && tst_nxt == TX_SEND) ? tsh_nxt[0] : 1'b1;
  end

  // Registers only.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      {tst_r, tsh_r, tbits_r, tsub_r} <= {TX_IDLE, 11'h7ff, 4'h0, 4'h0};
      {tdr_r, tdr_full_r, tc_r} <= {9'h000, 1'b0, ASU_RST_TC};
      {te_d_r, pre_r, brk_r, txd_o, txd_oe_o} <= 5'b00010;
    end else begin
      {tst_r, tsh_r, tbits_r, tsub_r} <= {tst_nxt, tsh_nxt, tbits_nxt, tsub_nxt};
      {tdr_r, tdr_full_r, tc_r} <= {tdr_nxt, tdr_full_nxt, tc_nxt};
      {te_d_r, pre_r, brk_r, txd_o, txd_oe_o} <= {te, pre_nxt, brk_nxt, txd_nxt, ctrl2_nxt[ASU_B_TE]};
    end
  end

  // ---------------------------------------------------------------
  // Receiver and its flags
  // ---------------------------------------------------------------
  asu_rx_if rx_ev ();

  asu_rx_core u_rx (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .enable(re),
    .tick(rx_tick),
    .rxd(rxd_i),
    .nine_bit(m),
    .ev(rx_ev.core)
  );

  logic rx_msb, take;
  assign rx_msb = m ? rx_ev.data[8] : rx_ev.data[7];

  // Clears by the status-then-data sequence come first, so an event in
  // the same cycle wins over the clear and is never lost.
  always_comb begin
    {rx_full_flag_nxt, idle_nxt, ovr_nxt, nf_nxt, fe_nxt} = {rx_full_flag_r, idle_r, ovr_r, nf_r, fe_r};
    {idle_ok_nxt, rdr_nxt, r8_nxt} = {idle_ok_r, rdr_r, r8_r};
    mute_nxt = mute_r;
    take = 1'b0;
    if (wr && wb_adr_i == ASU_OFS_CTRL2) mute_nxt = wb_dat_i[1];
    if (rd_data && seen_r) begin
      {rx_full_flag_nxt, idle_nxt, ovr_nxt, nf_nxt, fe_nxt} = 5'b00000;
    end
    if (rx_ev.done) begin
      if (!mute_r) begin
        take = 1'b1;
      end else if (ctrl1_r[ASU_B_WAKE] && rx_msb) begin
        {take, mute_nxt} = 2'b10;
      end
    end
    if (take) begin
      if (rx_full_flag_nxt) begin
        ovr_nxt = 1'b1;
      end else begin
        {rdr_nxt, r8_nxt} = {rx_ev.data[7:0], rx_ev.data[8]};
        {rx_full_flag_nxt, idle_ok_nxt} = 2'b11;
        nf_nxt = rx_ev.noise;
        fe_nxt = rx_ev.ferr;
      end
    end
    if (rx_ev.idle) begin
      if (mute_r) begin
        if (!ctrl1_r[ASU_B_WAKE]) mute_nxt = 1'b0;
      end else if (idle_ok_r) begin
        {idle_nxt, idle_ok_nxt} = 2'b10;
      end
    end
    if (!re) begin
      {rx_full_flag_nxt, idle_nxt, ovr_nxt, nf_nxt, fe_nxt} = 5'b00000;
    end
  end

  // Registers only.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      {rx_full_flag_r, idle_r, ovr_r, nf_r, fe_r} <= 5'b00000;
      {idle_ok_r, rdr_r, r8_r, mute_r} <= {1'b1, 8'h00, 1'b0, 1'b0};
    end else begin
      {rx_full_flag_r, idle_r, ovr_r, nf_r, fe_r} <= {rx_full_flag_nxt, idle_nxt, ovr_nxt, nf_nxt, fe_nxt};
      {idle_ok_r, rdr_r, r8_r, mute_r} <= {idle_ok_nxt, rdr_nxt, r8_nxt, mute_nxt};
    end
  end

  // ---------------------------------------------------------------
  // Interrupt request
  // ---------------------------------------------------------------
  logic irq_nxt, rx_irq;

  // One shared line; receive sources stay quiet while muted, and noise
  // or framing never interrupt on their own.
  always_comb begin
    rx_irq = ~mute_r & ((ctrl2_r[ASU_B_RIE] & (rx_full_flag_r | ovr_r)) | (ctrl2_r[ASU_B_IDLE_IRQ_ENABLE] & idle_r));
    irq_nxt = ~global_irq_mask & (rx_irq
      | (ctrl2_r[ASU_B_TIE] & ~tdr_full_r) | (ctrl2_r[ASU_B_TX_DONE_IRQ_ENABLE] & tc_r));
  end

  // Registers only; wake-up from wait follows the line, halt is never ended.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      {irq_o, wake_req_o} <= 2'b00;
    end else begin
      irq_o <= irq_nxt;
      wake_req_o <= irq_nxt & wait_mode_i & ~halt_i;
    end
  end
endmodule : asu_top
`default_nettype wire

//--- tb/asu_sva.sv
// Port-level assertions for the async serial unit.
`timescale 1ns/1ps
`default_nettype none
module asu_sva (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Register bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // Line and CPU side
  input wire logic txd_o,
  input wire logic global_irq_mask,
  input wire logic wait_mode_i,
  input wire logic halt_i,
  input wire logic irq_o,
  input wire logic wake_req_o
);
  // One clock domain, so clock and reset are stated once for all.
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  chk_ack_given: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack missing");
  chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  chk_dat_upper: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0) else $error("upper data set");
  chk_irq_masked: assert property (global_irq_mask |=> !irq_o) else $error("irq while masked");
  chk_halt_nowake: assert property (halt_i |=> !wake_req_o) else $error("wake in halt");
  chk_wake_cause: assert property (wake_req_o |-> $past(wait_mode_i) && !$past(halt_i)) else $error("stray wake");
  chk_wake_irq: assert property ((irq_o && wait_mode_i && !halt_i) [*2] |-> wake_req_o) else $error("no wake");
  // Three cycles of halt let the frozen tick pipeline settle first.
  chk_halt_freeze: assert property (halt_i [*3] |=> $stable(txd_o)) else $error("line moved in halt");
endmodule : asu_sva
bind asu_top asu_sva chk_u (.ref_clk(ref_clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .txd_o(txd_o), .global_irq_mask(global_irq_mask),
  .wait_mode_i(wait_mode_i), .halt_i(halt_i), .irq_o(irq_o), .wake_req_o(wake_req_o));
`default_nettype wire

//--- tb/asu_line_model.sv
// Far-end serial transmitter that feeds the unit's receive line.
`timescale 1ns/1ps
`default_nettype none
module asu_line_model (
  // Clock
  input wire logic ref_clk,
  // Serial line towards the unit
  output logic rxd
);
  // The line rests at the mark level between frames.
  initial rxd = 1'b1;
  // Start, nb bits LSB first, stop; nz flips a short spot inside bit one.
  task automatic send(input logic [8:0] w, input int nb, input int bc, input logic stp, input logic nz);
    logic b;
    for (int i = 0; i < nb + 2; i++) begin
      b = (i == 0) ? 1'b0 : (i > nb) ? stp : w[i - 1];
      for (int c = 0; c < bc; c++) begin
        rxd <= b ^ (nz && i == 1 && c >= bc / 2 - 1 && c <= bc / 2 + 3);
        @(posedge ref_clk);
      end
    end
    rxd <= 1'b1;
  endtask : send
endmodule : asu_line_model
`default_nettype wire

//--- tb/asu_top_tb.sv
// Self-checking bench for the async serial unit.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin fail_count++; $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module asu_top_tb
  import asu_pkg::*;
;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0;
  logic global_irq_mask = 1'b0;
  logic wait_mode_i = 1'b0;
  logic halt_i = 1'b0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o, rxd_i, txd_o, txd_oe_o, irq_o, wake_req_o;
  logic [7:0] rv;
  int fail_count = 0;
  int total_checks = 0;
  int cyc = 0;
  // Clock of 5 ns.
  always #2.5 ref_clk = ~ref_clk;
  asu_top dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(4'hf), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .rxd_i(rxd_i), .txd_o(txd_o), .txd_oe_o(txd_oe_o), .global_irq_mask(global_irq_mask),
    .wait_mode_i(wait_mode_i), .halt_i(halt_i), .irq_o(irq_o), .wake_req_o(wake_req_o));
  asu_line_model line_u (.ref_clk(ref_clk), .rxd(rxd_i));
  // One classic cycle, held until ack is sampled high.
  task automatic wb(input logic we, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= {24'h0, d};
    @(posedge ref_clk);
    while (wb_ack_o !== 1'b1) @(posedge ref_clk);
    q = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge ref_clk);
  endtask : wb
  // Reads status until a flag in m shows; the last read opens a clear sequence.
  task automatic poll(input logic [7:0] m);
    rv = 8'h00;
    for (int n = 0; n < 400 && (rv & m) == 8'h00; n++) wb(1'b0, ASU_OFS_STATUS, 8'h00, rv);
  endtask : poll
  // Sends 0xff and counts the clocks of its start bit.
  task automatic tx_len(input logic [7:0] baud, input logic [7:0] fine, input int len);
    int n;
    n = 0;
    wb(1'b1, ASU_OFS_CTRL2, 8'h00, rv);
    wb(1'b1, ASU_OFS_BAUD, baud, rv);
    wb(1'b1, ASU_OFS_TXFINE, fine, rv);
    wb(1'b1, ASU_OFS_CTRL2, 8'h08, rv);
    wb(1'b1, ASU_OFS_DATA, 8'hff, rv);
    for (int w = 0; w < 20 * len && txd_o !== 1'b0; w++) @(posedge ref_clk);
    while (txd_o === 1'b0 && n < 2 * len) begin
      @(posedge ref_clk);
      n++;
    end
    `CHK("start bit clocks", len, n)
  endtask : tx_len
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    wb(1'b0, ASU_OFS_STATUS, 8'h00, rv);
    `CHK("status reset", 8'hc0, rv)
    wb(1'b0, 8'h1c, 8'h00, rv);
    `CHK("unmapped read", 8'h00, rv)
    $display("test reset done");
  endtask : t_reset
  task automatic t_rate();
    int pr [4] = '{1, 3, 4, 13};
    for (int c = 0; c < 4; c++) tx_len({c[1:0], 6'h05}, 8'h00, 32 * pr[c]);
    for (int e = 0; e < 7; e++) tx_len({2'b00, e[2:0], 3'h7 - e[2:0]}, 8'h00, 32 << e);
    tx_len(8'h3f, 8'h01, 16);
    tx_len(8'h00, 8'h03, 48);
    $display("test rate done");
  endtask : t_rate
  task automatic t_irq();
    wb(1'b1, ASU_OFS_CTRL2, 8'h80, rv);
    repeat (3) @(posedge ref_clk);
    `CHK("irq tx empty", 1'b1, irq_o)
    global_irq_mask <= 1'b1;
    repeat (3) @(posedge ref_clk);
    `CHK("irq masked", 1'b0, irq_o)
    global_irq_mask <= 1'b0;
    wait_mode_i <= 1'b1;
    wb(1'b1, ASU_OFS_CTRL2, 8'h48, rv);
    repeat (3) @(posedge ref_clk);
    `CHK("irq tx done", 1'b1, irq_o)
    `CHK("wake in wait", 1'b1, wake_req_o)
    `CHK("tx pin driven", 1'b1, txd_oe_o)
    wb(1'b1, ASU_OFS_DATA, 8'h0f, rv);
    for (int n = 0; n < 2000 && txd_o !== 1'b0; n++) @(posedge ref_clk);
    halt_i <= 1'b1;
    repeat (300) @(posedge ref_clk);
    `CHK("line frozen", 1'b0, txd_o)
    `CHK("no wake in halt", 1'b0, wake_req_o)
    halt_i <= 1'b0;
    wait_mode_i <= 1'b0;
    wb(1'b1, ASU_OFS_CTRL2, 8'h00, rv);
    $display("test irq done");
  endtask : t_irq
  task automatic t_rx();
    wb(1'b1, ASU_OFS_RXFINE, 8'h04, rv);
    wb(1'b1, ASU_OFS_CTRL2, 8'h24, rv);
    line_u.send(9'h05a, 8, 64, 1'b1, 1'b0);
    poll(8'h20);
    `CHK("irq rx full", 1'b1, irq_o)
    line_u.send(9'h0a5, 8, 64, 1'b0, 1'b0);
    poll(8'h08);
    `CHK("overrun flags", 8'h28, rv & 8'h2e)
    `CHK("irq overrun", 1'b1, irq_o)
    wb(1'b0, ASU_OFS_DATA, 8'h00, rv);
    `CHK("data kept", 8'h5a, rv)
    wb(1'b0, ASU_OFS_STATUS, 8'h00, rv);
    `CHK("flags cleared", 8'h00, rv & 8'h2e)
    $display("test rx done");
  endtask : t_rx
  task automatic t_idle();
    wb(1'b1, ASU_OFS_CTRL2, 8'h14, rv);
    poll(8'h10);
    repeat (3) @(posedge ref_clk);
    `CHK("irq idle", 1'b1, irq_o)
    wb(1'b0, ASU_OFS_DATA, 8'h00, rv);
    repeat (1500) @(posedge ref_clk);
    wb(1'b0, ASU_OFS_STATUS, 8'h00, rv);
    `CHK("idle not rearmed", 8'h00, rv & 8'h10)
    $display("test idle done");
  endtask : t_idle
  task automatic t_errs();
    line_u.send(9'h0ff, 8, 64, 1'b1, 1'b1);
    poll(8'h20);
    `CHK("noise flags", 8'h24, rv & 8'h26)
    `CHK("no noise irq", 1'b0, irq_o)
    wb(1'b0, ASU_OFS_DATA, 8'h00, rv);
    line_u.send(9'h000, 8, 64, 1'b0, 1'b0);
    poll(8'h20);
    `CHK("break flags", 8'h22, rv & 8'h26)
    wb(1'b0, ASU_OFS_DATA, 8'h00, rv);
    `CHK("break data", 8'h00, rv)
    line_u.send(9'h03c, 8, 64, 1'b1, 1'b0);
    poll(8'h20);
    wb(1'b1, ASU_OFS_CTRL2, 8'h00, rv);
    wb(1'b0, ASU_OFS_STATUS, 8'h00, rv);
    `CHK("disable clears", 8'h00, rv & 8'h3e)
    $display("test errors done");
  endtask : t_errs
  task automatic t_mute();
    wb(1'b1, ASU_OFS_CTRL2, 8'h26, rv);
    line_u.send(9'h033, 8, 64, 1'b1, 1'b0);
    repeat (4) @(posedge ref_clk);
    `CHK("irq muted", 1'b0, irq_o)
    repeat (1400) @(posedge ref_clk);
    wb(1'b0, ASU_OFS_STATUS, 8'h00, rv);
    `CHK("muted flags", 8'h00, rv & 8'h3e)
    wb(1'b0, ASU_OFS_CTRL2, 8'h00, rv);
    `CHK("idle wake", 8'h00, rv & 8'h02)
    wb(1'b1, ASU_OFS_CTRL1, 8'h08, rv);
    wb(1'b1, ASU_OFS_CTRL2, 8'h26, rv);
    line_u.send(9'h012, 8, 64, 1'b1, 1'b0);
    line_u.send(9'h092, 8, 64, 1'b1, 1'b0);
    poll(8'h20);
    wb(1'b0, ASU_OFS_DATA, 8'h00, rv);
    `CHK("address word", 8'h92, rv)
    wb(1'b0, ASU_OFS_CTRL2, 8'h00, rv);
    `CHK("address wake", 8'h24, rv)
    $display("test mute done");
  endtask : t_mute
  // Prints the counts and the verdict, then stops.
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : complete_run
  // Cuts a hang short well above the expected run length.
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 95000) begin
      fail_count++;
      complete_run();
    end
  end
  // Main sequence after ten reset cycles.
  initial begin
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    t_reset();
    t_rate();
    t_irq();
    t_rx();
    t_idle();
    t_errs();
    t_mute();
    complete_run();
  end
endmodule : asu_top_tb
`default_nettype wire
